/* hw/simple_link_user_port.sv */
`timescale 1ns/1ps
`default_nettype none
module simple_link_user_port (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // source user port
    input  wire logic        user_write_clock,
    input  wire logic        user_write_enable_n,
    input  wire logic [31:0] user_data_in,
    input  wire logic        user_control_flag_n,
    output logic             source_full_flag_n,
    // destination user port
    output logic             dest_output_clock,
    output logic             dest_write_enable_n,
    output logic [31:0]      dest_data_out,
    output logic             dest_control_flag_n,
    output logic             dest_error_flag_n,
    output logic             link_not_operational_n,
    output logic             data_error_led
);

    // ---------------- register bus ----------------

    logic [1:0]  control;        // enable, word mode
    logic [1:0]  inject;         // pending fault injections
    logic [15:0] delivered;      // words handed to read-out
    logic        dp_write;       // data phase is a write
    logic        dp_read;        // data phase is a read
    logic [3:0]  dp_addr;        // data phase register address

    // an address phase is taken only when the bus is ready
    // (hready is this slave's own hreadyout, tied on the bus)
    wire ap_take = hsel & hready & htrans[1];

    // zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // capture the address phase for the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_addr  <= '0;
        end else if (hready) begin
            dp_write <= ap_take & hwrite;
            dp_read  <= ap_take & ~hwrite;
            dp_addr  <= haddr[link_port_pkg::ADDR_W-1:0];
        end
    end

    // register write strobes, valid while hwdata stands
    wire wr_control = dp_write & (dp_addr == link_port_pkg::REG_CONTROL);
    wire wr_inject  = dp_write & (dp_addr == link_port_pkg::REG_INJECT);
    wire wr_status  = dp_write & (dp_addr == link_port_pkg::REG_STATUS);

    wire link_enable = control[link_port_pkg::CTL_ENABLE];
    wire word_mode   = control[link_port_pkg::CTL_WORD_MODE];

    // queue level, for status
    logic [link_port_pkg::LEVEL_W-1:0] q_level;

    // status word assembled from live state
    wire [31:0] status_word = {25'h0, q_level, 2'h0,
                               ~source_full_flag_n, data_error_led};

    // read mux in the data phase, so a write just before is seen
    wire [31:0] read_mux =
        (dp_addr == link_port_pkg::REG_CONTROL)   ? {30'h0, control} :
        (dp_addr == link_port_pkg::REG_INJECT)    ? {30'h0, inject}  :
        (dp_addr == link_port_pkg::REG_STATUS)    ? status_word      :
        (dp_addr == link_port_pkg::REG_DELIVERED) ? {16'h0, delivered} :
        32'h0;                   // unmapped reads as zero
    assign hrdata = dp_read ? read_mux : 32'h0;

    // word mode may change mid-block; the open block then reports
    // under the new mode, which is the cheaper choice
    // control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            control <= link_port_pkg::CONTROL_RST;
        else if (wr_control)
            control <= hwdata[1:0];
    end

    // ---------------- source side capture ----------------

    logic [34:0] pins_sync;      // clock, enable, flag, word
    logic        user_write_clock_prev;      // last synced write clock level

    // every pin passes two flops before use
    bit_sync #(
        .WIDTH (35)
    ) u_pin_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({user_write_clock, user_write_enable_n,
                   user_control_flag_n, user_data_in}),
        .q       (pins_sync)
    );

    wire        s_user_write_clock   = pins_sync[34];
    wire        s_wen_n  = pins_sync[33];
    wire        s_ctrl_n = pins_sync[32];
    wire [31:0] s_data   = pins_sync[31:0];

    // prev resets low like the synced clock, so no false edge
    // follows reset; the synced enable also resets low but cannot
    // capture until the synced clock rises
    // rising edge of the synced write clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            user_write_clock_prev <= 1'b0;
        else
            user_write_clock_prev <= s_user_write_clock;
    end

    wire capture = s_user_write_clock & ~user_write_clock_prev & ~s_wen_n;

    // nibble zeroed before the queue so parity covers the word as sent
    // control nibble ignored
    wire [31:0] src_word = s_ctrl_n ? s_data
                         : {s_data[31:link_port_pkg::LINK_BITS_W], 4'h0};

    // ---------------- source queue ----------------

    logic                              q_pop;
    logic [link_port_pkg::ENTRY_W-1:0] q_head;
    logic                              q_empty;

    // depth four with full at two gives exactly the promised slack
    // mark and word carried together
    word_queue u_queue (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .push      (capture),
        .push_data ({~s_ctrl_n, src_word}),
        .pop       (q_pop),
        .pop_data  (q_head),
        .level     (q_level),
        .empty     (q_empty)
    );

    // registered, so the flag trails the level by one hclk; the
    // two slots of slack cover that lag as well
    // full at two, two slots left
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            source_full_flag_n <= 1'b1;
        else
            source_full_flag_n <= (q_level < link_port_pkg::FULL_LEVEL);
    end

    // ---------------- link and destination ----------------

    logic block_err;             // error seen in the open block

    // toggling every hclk keeps it at 20 MHz, under the 40 MHz limit
    // half rate, link up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            dest_output_clock <= 1'b0;
        else
            dest_output_clock <= link_enable & ~dest_output_clock;
    end
    // link-down is only the enable bit: no failure state is modelled
    assign link_not_operational_n = link_enable;

    // outputs move on the falling output clock edge, a full
    // half period ahead of the rising edge the receiver uses
    wire out_slot = link_enable & dest_output_clock;
    // limitation: one word per two hclk at most, so the queue only
    // fills when the sender outruns that or the link is stopped

    // pop only with a word ready
    assign q_pop = out_slot & ~q_empty;

    wire        hd_ctrl = q_head[link_port_pkg::WORD_W];
    wire [31:0] hd_word = q_head[link_port_pkg::WORD_W-1:0];

    // parity sent with the word, before the channel
    // single-bit faults only: an even number of flips goes unseen
    wire sent_par = link_port_pkg::word_parity(q_head);

    // fault injection flips one bit in the channel
    // the damaged word goes out as is: flagged, never repaired
    wire inj_hit = hd_ctrl ? inject[link_port_pkg::INJ_CTRL]
                           : inject[link_port_pkg::INJ_DATA];
    wire [31:0] rx_word = hd_word ^
                          (32'(inj_hit) << link_port_pkg::INJECT_BIT);

    wire rx_bad = link_port_pkg::word_parity({hd_ctrl, rx_word}) != sent_par;

    wire [31:0] ctrl_out = {rx_word[31:link_port_pkg::LINK_BITS_W],
                            2'b00, rx_bad, block_err};

    // a bad data word in block mode stays silent until its block closes
    // error flag per mode
    wire report = hd_ctrl ? (rx_bad | block_err) : (word_mode & rx_bad);

    // data, flag and error load only with a word; when the queue runs
    // dry the last word stays visible with the enable high
    // destination word outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dest_write_enable_n <= 1'b1;
            dest_data_out       <= 32'h0;
            dest_control_flag_n <= 1'b1;
            dest_error_flag_n   <= 1'b1;
        end else if (!link_enable) begin
            dest_write_enable_n <= 1'b1;
        end else if (out_slot) begin
            dest_write_enable_n <= q_empty;
            if (!q_empty) begin
                dest_data_out       <= hd_ctrl ? ctrl_out : rx_word;
                dest_control_flag_n <= ~hd_ctrl;
                dest_error_flag_n   <= ~report;
            end
        end
    end

    // a control word closes the block even when it is itself damaged
    // accumulate, clear on control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            block_err <= 1'b0;
        else if (q_pop)
            block_err <= hd_ctrl ? 1'b0 : (block_err | rx_bad);
    end

    // a use clears only its own bit, and a write sets on top, so a
    // request written in the same cycle is never swallowed
    wire [1:0] inj_used = (q_pop && inj_hit)
                        ? (hd_ctrl ? 2'b10 : 2'b01) : 2'b00;
    wire [1:0] inj_new  = wr_inject ? hwdata[1:0] : 2'b00;

    // pending injections
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            inject <= link_port_pkg::INJECT_RST;
        else
            inject <= (inject & ~inj_used) | inj_new;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            data_error_led <= 1'b0;
        else if (q_pop && report)
            data_error_led <= 1'b1;
        else if (wr_status && hwdata[link_port_pkg::ST_ERR_HELD])
            data_error_led <= 1'b0;
    end

    // a debug count only; nothing in the link depends on it
    // delivered word counter, wraps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            delivered <= link_port_pkg::DELIVERED_RST;
        else if (q_pop)
            delivered <= delivered + 16'h1;
    end

    // hsize is unused: only whole words are supported
    wire unused_ok = &{1'b0, hsize, haddr[31:4]};

endmodule
`default_nettype wire

/* hw/link_port_pkg.sv */
package link_port_pkg;

    // clock figures
    localparam int HCLK_MHZ           = 40;  // system clock rate
    localparam int MAX_LINK_CLOCK_MHZ = 40;  // ceiling for either side
    // output clock toggles every hclk edge, so it runs at half rate
    localparam int DEST_CLOCK_DIV     = 2;
    localparam int DEST_CLOCK_MHZ     = HCLK_MHZ / DEST_CLOCK_DIV;

    // word layout
    localparam int WORD_W        = 32;
    localparam int LINK_BITS_W   = 4;    // low bits owned by the link
    localparam int CW_BLOCK_ERR  = 0;    // previous block had an error
    localparam int CW_CTRL_ERR   = 1;    // control word itself damaged
    localparam int ENTRY_W       = WORD_W + 1;  // control mark + word
    localparam int INJECT_BIT    = 4;    // bit flipped by fault injection

    // source queue: two words of slack above the full threshold
    localparam int QUEUE_DEPTH   = 4;
    localparam int QUEUE_AW      = 2;
    localparam int LEVEL_W       = 3;
    localparam logic [2:0] FULL_LEVEL = 3'h2;

    // ahb-lite register map (byte addresses)
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CONTROL   = 4'h0;
    localparam logic [3:0] REG_INJECT    = 4'h4;
    localparam logic [3:0] REG_STATUS    = 4'h8;
    localparam logic [3:0] REG_DELIVERED = 4'hC;

    // control register fields
    localparam int CTL_ENABLE    = 0;    // link running
    localparam int CTL_WORD_MODE = 1;    // 1 word-by-word, 0 per block
    // inject register fields
    localparam int INJ_DATA      = 0;    // corrupt next data word
    localparam int INJ_CTRL      = 1;    // corrupt next control word
    // status register fields
    localparam int ST_ERR_HELD   = 0;    // data error indicator, w1c
    localparam int ST_FULL       = 1;    // source full
    localparam int ST_LEVEL_LO   = 4;    // queue level, 3 bits

    // reset values
    localparam logic [1:0]  CONTROL_RST   = 2'h0;
    localparam logic [1:0]  INJECT_RST    = 2'h0;
    localparam logic [15:0] DELIVERED_RST = 16'h0000;

    // even parity over the mark and word
    function automatic logic word_parity(input logic [ENTRY_W-1:0] w);
        word_parity = ^w;
    endfunction

endpackage

/* hw/bit_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a group of pin inputs
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    // first stage, read only by the second stage
    logic [WIDTH-1:0] meta;

    // both stages reset to zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

/* hw/word_queue.sv */
`timescale 1ns/1ps
`default_nettype none
// small flip-flop queue between capture and the link
module word_queue (
    input  wire logic                                hclk,
    input  wire logic                                hresetn,
    input  wire logic                                push,
    input  wire logic [link_port_pkg::ENTRY_W-1:0]   push_data,
    input  wire logic                                pop,
    output logic      [link_port_pkg::ENTRY_W-1:0]   pop_data,
    output logic      [link_port_pkg::LEVEL_W-1:0]   level,
    output logic                                     empty
);
    // storage and pointers
    logic [link_port_pkg::ENTRY_W-1:0] mem [link_port_pkg::QUEUE_DEPTH];
    logic [link_port_pkg::QUEUE_AW-1:0] wr_ptr;
    logic [link_port_pkg::QUEUE_AW-1:0] rd_ptr;
    wire  full_now = (level == 3'(link_port_pkg::QUEUE_DEPTH));
    // a push into a full queue is dropped: that word is lost
    wire  do_push  = push & ~full_now;
    wire  do_pop   = pop & ~empty;

    assign empty    = (level == 3'h0);
    assign pop_data = mem[rd_ptr];

    // pointer and level bookkeeping
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end else begin
            if (do_push)
                wr_ptr <= wr_ptr + 2'h1;
            if (do_pop)
                rd_ptr <= rd_ptr + 2'h1;
            level <= level + 3'(do_push) - 3'(do_pop);
        end
    end

    // storage has no reset; contents are gated by level
    always_ff @(posedge hclk) begin
        if (do_push)
            mem[wr_ptr] <= push_data;
    end
endmodule
`default_nettype wire

/* sim/link_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// pin and bus checks beside the block
module link_port_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic        dest_output_clock,
    input wire logic        dest_write_enable_n,
    input wire logic [31:0] dest_data_out,
    input wire logic        dest_control_flag_n,
    input wire logic        dest_error_flag_n,
    input wire logic        link_not_operational_n,
    input wire logic        data_error_led
);
    logic rd_ph;  // read data phase
    logic st_wr;  // status write data phase
    wire  take   = hsel && hready && htrans[1];
    wire  st_hit = haddr[3:0] == link_port_pkg::REG_STATUS;
    wire  ow     = !dest_write_enable_n;  // word offered
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // data phase tracking, one cycle behind the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ph <= 1'b0;
            st_wr <= 1'b0;
        end else begin
            rd_ph <= take && !hwrite;
            st_wr <= take && hwrite && st_hit;
        end
    end
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus stalled or not okay");
    a_rdata_idle: assert property (!rd_ph |-> hrdata == 32'h0)
        else $error("read data outside read phase");
    a_clk_held: assert property (!link_not_operational_n[*2] |->
        !dest_output_clock && dest_write_enable_n)
        else $error("output clock or enable active while down");
    a_clk_runs: assert property (link_not_operational_n[*2] |=>
        dest_output_clock != $past(dest_output_clock))
        else $error("output clock not toggling");
    a_wen_falling: assert property (link_not_operational_n &&
        $changed(dest_write_enable_n) |->
        $past(dest_output_clock) && !dest_output_clock)
        else $error("enable moved off the falling clock");
    a_word_stands: assert property ($rose(dest_output_clock) |->
        $stable(dest_data_out) && $stable(dest_error_flag_n))
        else $error("word changed at latch edge");
    a_reserved_zero: assert property (ow && !dest_control_flag_n |->
        dest_data_out[3:2] == 2'h0)
        else $error("reserved control bits set");
    a_ctrl_err: assert property (ow && !dest_control_flag_n |->
        dest_error_flag_n == !(dest_data_out[1] || dest_data_out[0]))
        else $error("control error flag disagrees");
    a_led_clear: assert property ($fell(data_error_led) |->
        $past(st_wr) && $past(hwdata[0]))
        else $error("led dropped without clear");
    a_led_set: assert property (ow && !dest_error_flag_n |->
        ##[0:2] data_error_led)
        else $error("led not lit on error");
    c_blk: cover property (ow && !dest_control_flag_n && dest_data_out[0]);
    c_ctl: cover property (ow && !dest_control_flag_n && dest_data_out[1]);
    c_wrd: cover property (ow && dest_control_flag_n && !dest_error_flag_n);
endmodule
`default_nettype wire

/* sim/link_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// front-end writer and read-out receiver
module link_partner (
    input wire logic        source_full_flag_n,
    input wire logic        dest_output_clock,
    input wire logic        dest_write_enable_n,
    input wire logic [31:0] dest_data_out,
    input wire logic        dest_control_flag_n,
    input wire logic        dest_error_flag_n,
    output logic            user_write_clock,
    output logic            user_write_enable_n,
    output logic [31:0]     user_data_in,
    output logic            user_control_flag_n
);
    logic [33:0] rx_q[$];  // received err, ctrl, word
    int          extra;    // writes since full seen
    int          overrun;  // writes past the slack
    initial begin
        user_write_clock = 1'b0;
        user_write_enable_n = 1'b1;
        user_data_in = 32'h0;
        user_control_flag_n = 1'b1;
        extra = 0;
        overrun = 0;
        #3.3;
        forever #100 user_write_clock = ~user_write_clock;
    end
    // drive at falling, taken at rising
    task send(input logic [31:0] d, input logic c_n);
        @(negedge user_write_clock);
        user_data_in <= d;
        user_control_flag_n <= c_n;
        user_write_enable_n <= 1'b0;
        @(posedge user_write_clock);
    endtask
    // released pins show the inverse, not the old word
    task stop;
        @(negedge user_write_clock);
        user_write_enable_n <= 1'b1;
        user_data_in <= ~user_data_in;
    endtask
    always @(posedge user_write_clock) begin
        if (source_full_flag_n) extra = 0;
        else if (!user_write_enable_n) extra = extra + 1;
        if (extra > 2) overrun = overrun + 1;
    end
    always @(posedge dest_output_clock) begin
        if (dest_write_enable_n === 1'b0)
            rx_q.push_back({dest_error_flag_n, dest_control_flag_n,
                            dest_data_out});
    end
endmodule
`default_nettype wire

/* sim/simple_link_user_port_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module simple_link_user_port_tb_top;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, user_data_in, dest_data_out, x;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        user_write_clock, user_write_enable_n, user_control_flag_n;
    logic        source_full_flag_n, dest_output_clock, dest_write_enable_n;
    logic        dest_control_flag_n, dest_error_flag_n, data_error_led;
    logic        link_not_operational_n;
    logic [33:0] exp_q[$];  // model of delivered words
    int          err_total, tests_run, cycles, a;
    bit          wm, blk;   // word mode, block error held
    simple_link_user_port simple_link_user_port_inst (.*, .hready(hreadyout));
    link_partner link_partner_inst (.*);
    always #12.5 hclk = ~hclk;
    // hang guard
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_of_test;
        end
    end
    task check(input string n, input logic [33:0] s, input logic [33:0] e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // one single ahb transfer, zero or more waits
    task ahb(input logic w, input logic [3:0] ad, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {28'h0, ad};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        x = hrdata;
        hsel <= 1'b0;
    endtask
    task rdc(input string n, input logic [3:0] ad, input logic [31:0] e);
        ahb(1'b0, ad, 32'h0);
        check(n, x, e);
    endtask
    // model a word, then send it
    task xfer(input logic [31:0] d, input logic c_n, input bit bad);
        logic [31:0] v;
        v = d ^ (bad ? 32'h1 << link_port_pkg::INJECT_BIT : 32'h0);
        if (c_n) begin
            exp_q.push_back({!(wm && bad), 1'b1, v});
            blk = blk | bad;
        end else begin
            exp_q.push_back({!(bad | blk), 1'b0, v[31:4], 2'h0, bad, blk});
            blk = 0;
        end
        link_partner_inst.send(d, c_n);
    endtask
    task drain;
        link_partner_inst.stop();
        for (a = 0; a < 2000; a++) begin
            if (link_partner_inst.rx_q.size() >= exp_q.size()) break;
            @(posedge hclk);
        end
        check("count", link_partner_inst.rx_q.size(), exp_q.size());
        while (exp_q.size() > 0 && link_partner_inst.rx_q.size() > 0)
            check("word", link_partner_inst.rx_q.pop_front(),
                  exp_q.pop_front());
        exp_q.delete();
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0;
        hwrite = 0; hwdata = 0; hsize = 3'h2; err_total = 0;
        tests_run = 0; cycles = 0; wm = 0; blk = 0;
        void'($urandom(43));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        // every register resets to zero
        for (int i = 0; i < 16; i += 4) rdc("reset", 4'(i), 32'h0);
        check("down", link_not_operational_n, 1'b0);
        // link stopped: fill past the full threshold
        repeat (4) xfer($urandom, 1'b1, 0);
        link_partner_inst.stop();
        repeat (4) @(posedge hclk);
        check("full", source_full_flag_n, 1'b0);
        rdc("status", link_port_pkg::REG_STATUS, 32'h42);
        check("overrun", link_partner_inst.overrun, 0);
        ahb(1'b1, link_port_pkg::REG_CONTROL, 32'h1);
        // sender waits for room before it starts again
        wait (source_full_flag_n === 1'b1);
        xfer($urandom, 1'b0, 0);
        drain;
        check("full", source_full_flag_n, 1'b1);
        // damaged data word, block reporting
        ahb(1'b1, link_port_pkg::REG_INJECT, 32'h1);
        rdc("inject", link_port_pkg::REG_INJECT, 32'h1);
        xfer($urandom, 1'b1, 1);
        xfer($urandom, 1'b1, 0);
        xfer($urandom, 1'b0, 0);
        drain;
        check("led", data_error_led, 1'b1);
        rdc("status", link_port_pkg::REG_STATUS, 32'h1);
        ahb(1'b1, link_port_pkg::REG_STATUS, 32'h1);
        rdc("status", link_port_pkg::REG_STATUS, 32'h0);
        // clean block, damaged closing control word
        ahb(1'b1, link_port_pkg::REG_INJECT, 32'h2);
        xfer($urandom, 1'b1, 0);
        xfer($urandom, 1'b0, 1);
        drain;
        // word-by-word reporting
        wm = 1;
        ahb(1'b1, link_port_pkg::REG_CONTROL, 32'h3);
        ahb(1'b1, link_port_pkg::REG_INJECT, 32'h1);
        xfer($urandom, 1'b1, 1);
        xfer($urandom, 1'b1, 0);
        xfer($urandom, 1'b0, 0);
        drain;
        rdc("delivered", link_port_pkg::REG_DELIVERED, 32'hD);
        ahb(1'b1, link_port_pkg::REG_CONTROL, 32'h0);
        // the write lands at the edge that ends the task
        @(posedge hclk);
        check("down", link_not_operational_n, 1'b0);
        check("overrun", link_partner_inst.overrun, 0);
        end_of_test;
    end
endmodule
bind simple_link_user_port link_port_chk link_port_chk_inst (.*);
`default_nettype wire
